// *** bench/onc_host_model.sv ***
// Host logic model: drives preset-select pins, times channel A second-threshold over-range pin
`timescale 1ns/1ps
`default_nettype none
module onc_host_model (
  // Clock
  input wire logic ref_clk,
  // Bench requests
  input wire logic [1:0] selA,
  input wire logic [1:0] selB,
  input wire logic clrLen,
  // Pins
  input wire onc_pkg::onc_flags_type flagPins,
  output logic [1:0] chanAPresetPins,
  output logic [1:0] chanBPresetPins,
  // Measured high time of channel A second-threshold pin
  output logic [7:0] highLen
);
  import onc_pkg::*;
  initial begin
    chanAPresetPins = 2'h0;
    chanBPresetPins = 2'h0;
    highLen = 8'h00;
  end
  // Pins change just after the edge and then hold
  always @(posedge ref_clk) begin
    chanAPresetPins <= selA;
    chanBPresetPins <= selB;
    if (clrLen) begin
      highLen <= 8'h00;
    end else if (flagPins.flagA[1]) begin
      highLen <= highLen + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** bench/onc_overrange_nco_ctl_tb.sv ***
// Testbench for the over-range and preset control block
`timescale 1ns/1ps
`default_nettype none
module onc_overrange_nco_ctl_tb;
  import onc_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [9:0] regAddr = 10'h000;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdData;
  logic [11:0] convASample = 12'h000;
  logic [11:0] convBSample = 12'h000;
  logic [13:0] digASample, digBSample;
  onc_preset_type [3:0] chanAPresets, chanBPresets;
  onc_preset_type chanAActive, chanBActive;
  logic [15:0] rationalDivisor;
  logic [1:0] chanAPresetPins, chanBPresetPins, selA, selB;
  onc_flags_type flagPins;
  logic chanAPowerDown, chanBPowerDown, serialLinkEnable, calEnable;
  logic clrLen = 1'b0;
  logic [7:0] highLen;
  int errCount = 0;
  int checkCount = 0;
  always #4 ref_clk = ~ref_clk;
  onc_overrange_nco_ctl DUT (.ref_clk(ref_clk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .convASample(convASample),
    .convBSample(convBSample), .digASample(digASample),
    .digBSample(digBSample), .chanAPresets(chanAPresets),
    .chanBPresets(chanBPresets), .chanAActive(chanAActive),
    .chanBActive(chanBActive), .rationalDivisor(rationalDivisor),
    .chanAPresetPins(chanAPresetPins), .chanBPresetPins(chanBPresetPins),
    .flagPins(flagPins), .chanAPowerDown(chanAPowerDown),
    .chanBPowerDown(chanBPowerDown), .serialLinkEnable(serialLinkEnable),
    .calEnable(calEnable));
  onc_host_model host (.ref_clk(ref_clk), .selA(selA), .selB(selB),
    .clrLen(clrLen), .flagPins(flagPins), .chanAPresetPins(chanAPresetPins),
    .chanBPresetPins(chanBPresetPins), .highLen(highLen));
  ////////////////////////////////////////////////////////////////////////
  task automatic reportAndStop();
    $display("Checks %0d errors %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chkVal(input string nm, input logic [47:0] exp,
                        input logic [47:0] got);
    checkCount++;
    if (got !== exp) begin
      errCount++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    chkVal("regRdData", {40'h0, exp}, {40'h0, regRdData});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6000) @(posedge ref_clk);
    errCount++;
    reportAndStop();
  end
  initial begin
    selA = 2'h0;
    selB = 2'h0;
    for (int i = 0; i < 4; i++) begin
      chanAPresets[i] = {32'hA0000000 + i, 16'hA100 + 16'(i)};
      chanBPresets[i] = {32'hB0000000 + i, 16'hB100 + 16'(i)};
    end
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rd(10'h211, 8'hF2);
    rd(10'h212, 8'hAB);
    rd(10'h213, 8'h07);
    rd(10'h214, 8'h00);
    rd(10'h215, 8'h00);
    rd(10'h216, 8'h02);
    rd(10'h217, 8'h00);
    rd(10'h300, 8'h00);
    wr(10'h215, 8'hAE);
    rd(10'h215, 8'hAE);
    cyc(2);
    chkVal("chanAActive", chanAPresets[2], chanAActive);
    chkVal("chanBActive", chanBPresets[3], chanBActive);
    wr(10'h214, 8'h01);
    selA <= 2'h1;
    selB <= 2'h2;
    cyc(6);
    chkVal("chanAActive", chanAPresets[1], chanAActive);
    chkVal("chanBActive", chanBPresets[2], chanBActive);
    wr(10'h214, 8'h02);
    selA <= 2'h3;
    cyc(6);
    chkVal("chanAActive", chanAPresets[3], chanAActive);
    chkVal("chanBActive", chanBPresets[3], chanBActive);
    // Link and calibration are clear here, so rebinding is allowed
    convASample <= 12'h123;
    convBSample <= 12'h456;
    wr(10'h216, 8'h01);
    cyc(3);
    chkVal("digASample", 48'h456, 48'(digASample[11:0]));
    chkVal("digBSample", 48'h123, 48'(digBSample[11:0]));
    wr(10'h216, 8'h02);
    cyc(3);
    chkVal("digASample", 48'h123, 48'(digASample[11:0]));
    chkVal("digBSample", 48'h456, 48'(digBSample[11:0]));
    wr(10'h220, 8'h01);
    cyc(3);
    chkVal("chanAPowerDown", 48'h1, 48'(chanAPowerDown));
    chkVal("digASample", 48'h0, 48'(digASample));
    chkVal("chanBPowerDown", 48'h0, 48'(chanBPowerDown));
    wr(10'h220, 8'h0C);
    cyc(3);
    chkVal("serialLinkEnable", 48'h1, 48'(serialLinkEnable));
    chkVal("calEnable", 48'h1, 48'(calEnable));
    wr(10'h220, 8'h00);
    convASample <= 12'h557;
    cyc(3);
    chkVal("sampleFlags", 48'h0, 48'(digASample[13:12]));
    convASample <= 12'h558;
    cyc(3);
    chkVal("sampleFlags", 48'h2, 48'(digASample[13:12]));
    chkVal("flagPins", 48'h0, 48'(flagPins));
    convASample <= 12'h810;
    cyc(3);
    chkVal("sampleFlags", 48'h3, 48'(digASample[13:12]));
    convASample <= 12'hA00;
    cyc(3);
    chkVal("sampleFlags", 48'h2, 48'(digASample[13:12]));
    rd(10'h221, 8'h0C);
    convASample <= 12'h000;
    cyc(1100);
    for (int n = 0; n < 3; n += 2) begin
      wr(10'h213, 8'h08 | 8'(n));
      cyc(80);
      clrLen <= 1'b1;
      @(posedge ref_clk);
      clrLen <= 1'b0;
      convASample <= 12'h810;
      convBSample <= 12'h810;
      @(posedge ref_clk);
      convASample <= 12'h000;
      convBSample <= 12'h000;
      cyc(60);
      chkVal("pinRun", 48'h1, 48'(highLen >= (8 << n)));
      chkVal("pinRun", 48'h1, 48'(highLen <= (8 << n) + 1));
    end
    wr(10'h217, 8'h34);
    wr(10'h218, 8'h12);
    rd(10'h218, 8'h12);
    cyc(2);
    chkVal("rationalDivisor", 48'h1234, 48'(rationalDivisor));
    reportAndStop();
  end
endmodule
`default_nettype wire

// *** logic/onc_overrange_nco_ctl.sv ***
// Over-range detection, preset selection and channel binding control
//
// Function
// - Flag bit 1 sets when magnitude reaches second threshold, reset 0xAB.
// - Threshold means value over 256 of full scale.
// - Pin enable bit 3 low forces all four flag pins low.
// - Flags embedded in samples regardless of pin enable.
// - Pin pulses last at least 8 times 2^exponent clock cycles.
// - Changing exponent while link enabled may shift monitoring phase.
// - Four presets per channel, selected one drives the oscillator.
// - Mode 0 takes both presets from select register.
// - Mode 1 takes A from A pins, B from B pins.
// - Mode 2 uses A pins for both; mode 3 reserved.
// - Select bits 3-2 are channel B, bits 1-0 channel A.
// - Index n makes preset n words active.
// - Channel B source: 0 converter A, 1 converter B, default 1.
// - Channel A source: 0 converter A default, 1 converter B.
// - Digital channel powers down with its bound converter channel.
// - Flag bit 0 sets when magnitude reaches first threshold, reset 0xF2.
// - One rational divisor applies to every preset.
`timescale 1ns/1ps
`default_nettype none
module onc_overrange_nco_ctl
  import onc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register port
  input wire logic [onc_pkg::AddrW-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Samples
  input wire logic [onc_pkg::SampleW-1:0] convASample,
  input wire logic [onc_pkg::SampleW-1:0] convBSample,
  output logic [onc_pkg::SampleW+1:0] digASample,
  output logic [onc_pkg::SampleW+1:0] digBSample,
  // Preset tables
  input wire onc_pkg::onc_preset_type [onc_pkg::Presets-1:0] chanAPresets,
  input wire onc_pkg::onc_preset_type [onc_pkg::Presets-1:0] chanBPresets,
  output onc_pkg::onc_preset_type chanAActive,
  output onc_pkg::onc_preset_type chanBActive,
  output logic [15:0] rationalDivisor,
  // Pins
  input wire logic [1:0] chanAPresetPins,
  input wire logic [1:0] chanBPresetPins,
  output onc_pkg::onc_flags_type flagPins,
  // Power and link
  output logic chanAPowerDown,
  output logic chanBPowerDown,
  output logic serialLinkEnable,
  output logic calEnable
);
  import onc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] threshZero_q, threshOne_q, ovrCfg_q, srcMode_q;
  logic [7:0] presetSel_q, binding_q, powerCtl_q;
  logic [15:0] div_q;
  logic [1:0] pinsAMeta_q, pinsA_q, pinsBMeta_q, pinsB_q;

  function automatic logic [SampleW-2:0] magOf(
    input logic [SampleW-1:0] s
  );
    logic [SampleW-1:0] neg;
    neg = ~s + 1'b1;
    if (!s[SampleW-1]) begin
      magOf = s[SampleW-2:0];
    end else if (neg[SampleW-1]) begin
      // Most negative code saturates to full magnitude
      magOf = '1;
    end else begin
      magOf = neg[SampleW-2:0];
    end
  endfunction

  // Threshold scaled to full scale: value/256 of max magnitude
  function automatic logic hits(
    input logic [SampleW-2:0] m,
    input logic [ThreshW-1:0] t
  );
    hits = {1'b0, m} >= {1'b0, t, {(SampleW-1-ThreshW){1'b0}}};
  endfunction

  wire wrHit = regWrite;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      threshZero_q <= RstThreshZero;
      threshOne_q <= RstThreshOne;
      ovrCfg_q <= RstOvrCfg;
      srcMode_q <= RstSrcMode;
      presetSel_q <= RstPresetSel;
      binding_q <= RstBinding;
      div_q <= RstDiv;
      powerCtl_q <= RstPowerCtl;
    end else if (wrHit) begin
      // Full bytes stored, reserved bits included
      unique case (regAddr)
        OffThreshZero: threshZero_q <= regWrData;
        OffThreshOne: threshOne_q <= regWrData;
        OffOvrCfg: ovrCfg_q <= regWrData;
        OffSrcMode: srcMode_q <= regWrData;
        OffPresetSel: presetSel_q <= regWrData;
        OffBinding: binding_q <= regWrData;
        OffDivLow: div_q[7:0] <= regWrData;
        OffDivHigh: div_q[15:8] <= regWrData;
        OffPowerCtl: powerCtl_q <= regWrData;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pinsAMeta_q <= 2'h0;
      pinsA_q <= 2'h0;
      pinsBMeta_q <= 2'h0;
      pinsB_q <= 2'h0;
    end else begin
      pinsAMeta_q <= chanAPresetPins;
      pinsA_q <= pinsAMeta_q;
      pinsBMeta_q <= chanBPresetPins;
      pinsB_q <= pinsBMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Binding, detection and stretching
  wire bindA = binding_q[BindABit];
  wire bindB = binding_q[BindBBit];
  wire [SampleW-1:0] srcA = bindA ? convBSample : convASample;
  wire [SampleW-1:0] srcB = bindB ? convBSample : convASample;
  wire [SampleW-2:0] magA = magOf(srcA);
  wire [SampleW-2:0] magB = magOf(srcB);
  wire [1:0] hitA = {hits(magA, threshOne_q), hits(magA, threshZero_q)};
  wire [1:0] hitB = {hits(magB, threshOne_q), hits(magB, threshZero_q)};
  // Bit 1 second threshold, bit 0 first threshold
  wire [3:0] hitAll = {hitA, hitB};
  wire [2:0] expField = ovrCfg_q[ExpHi:0];
  wire [CntW-1:0] holdLen =
    CntW'(CntOne << (BaseCyclesLog + int'(expField)));
  wire pinEn = ovrCfg_q[PinEnBit];

  logic [CntW-1:0] holdCnt_q [4];
  logic [3:0] stretch_q;
  // Counters restart on every crossing; exponent change takes effect
  // on the next crossing, so the monitoring phase may shift
  for (genvar i = 0; i < 4; i++) begin : g_str
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        holdCnt_q[i] <= CntZero;
        stretch_q[i] <= 1'b0;
      end else if (hitAll[i]) begin
        holdCnt_q[i] <= holdLen - CntOne;
        stretch_q[i] <= 1'b1;
      end else if (holdCnt_q[i] != CntZero) begin
        holdCnt_q[i] <= holdCnt_q[i] - CntOne;
      end else begin
        stretch_q[i] <= 1'b0;
      end
    end
  end
  wire [3:0] stretchNow = hitAll | (stretch_q & {4{1'b1}} &
    {holdCnt_q[3] != CntZero, holdCnt_q[2] != CntZero,
     holdCnt_q[1] != CntZero, holdCnt_q[0] != CntZero});

  ////////////////////////////////////////////////////////////////////////////
  // Preset selection
  wire onc_src_type mode = onc_src_type'(srcMode_q[1:0]);
  logic [1:0] idxA, idxB;
  always_comb begin
    unique case (mode)
      ONC_SRC_REG: begin
        idxA = presetSel_q[SelAHi:SelALo];
        idxB = presetSel_q[SelBHi:SelBLo];
      end
      ONC_SRC_SPLIT: begin
        idxA = pinsA_q;
        idxB = pinsB_q;
      end
      ONC_SRC_SHARED: begin
        idxA = pinsA_q;
        idxB = pinsA_q;
      end
      default: begin
        idxA = presetSel_q[SelAHi:SelALo];
        idxB = presetSel_q[SelBHi:SelBLo];
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  wire pdA = powerCtl_q[bindA ? PdBBit : PdABit];
  wire pdB = powerCtl_q[bindB ? PdBBit : PdABit];
  wire linkEn = powerCtl_q[LinkEnBit];
  logic [7:0] rdMux;
  always_comb begin
    unique case (regAddr)
      OffThreshZero: rdMux = threshZero_q;
      OffThreshOne: rdMux = threshOne_q;
      OffOvrCfg: rdMux = ovrCfg_q;
      OffSrcMode: rdMux = srcMode_q;
      OffPresetSel: rdMux = presetSel_q;
      OffBinding: rdMux = binding_q;
      OffDivLow: rdMux = div_q[7:0];
      OffDivHigh: rdMux = div_q[15:8];
      OffPowerCtl: rdMux = powerCtl_q;
      OffStatus: rdMux = {4'h0, stretch_q};
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      regRdData <= 8'h00;
      digASample <= '0;
      digBSample <= '0;
      chanAActive <= '0;
      chanBActive <= '0;
      rationalDivisor <= RstDiv;
      flagPins <= '0;
      chanAPowerDown <= 1'b0;
      chanBPowerDown <= 1'b0;
      serialLinkEnable <= 1'b0;
      calEnable <= 1'b0;
    end else begin
      regRdData <= regRead ? rdMux : 8'h00;
      digASample <= pdA ? '0 : {hitA, srcA};
      digBSample <= pdB ? '0 : {hitB, srcB};
      chanAActive <= chanAPresets[idxA];
      chanBActive <= chanBPresets[idxB];
      rationalDivisor <= div_q;
      flagPins <= pinEn ? onc_flags_type'(stretchNow) : '0;
      chanAPowerDown <= pdA;
      chanBPowerDown <= pdB;
      serialLinkEnable <= linkEn & ~(pdA & pdB);
      calEnable <= powerCtl_q[CalEnBit];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_pin_off;
    @(posedge ref_clk) disable iff (reset)
    !pinEn |=> flagPins == '0;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pins not gated");

  property p_hit_one;
    @(posedge ref_clk) disable iff (reset)
    pinEn && hitA[1] |=> flagPins.flagA[1];
  endproperty
  a_hit_one: assert property (p_hit_one) else $error("t1 flag");

  property p_hit_zero;
    @(posedge ref_clk) disable iff (reset)
    pinEn && hitB[0] |=> flagPins.flagB[0];
  endproperty
  a_hit_zero: assert property (p_hit_zero) else $error("t0 flag");

  property p_stretch;
    @(posedge ref_clk) disable iff (reset)
    pinEn && hitA[0] && expField == 3'h0 ##1 pinEn [*7] |->
      flagPins.flagA[0];
  endproperty
  a_stretch: assert property (p_stretch) else $error("short pulse");

  property p_embed;
    @(posedge ref_clk) disable iff (reset)
    !pdA |=> digASample[SampleW+1:SampleW] == $past(hitA);
  endproperty
  a_embed: assert property (p_embed) else $error("embed");

  property p_mode_reg;
    @(posedge ref_clk) disable iff (reset)
    mode == ONC_SRC_REG |=>
      chanBActive == $past(chanBPresets[presetSel_q[SelBHi:SelBLo]]);
  endproperty
  a_mode_reg: assert property (p_mode_reg) else $error("reg mode");

  property p_mode_shared;
    @(posedge ref_clk) disable iff (reset)
    mode == ONC_SRC_SHARED |=>
      chanBActive == $past(chanBPresets[pinsA_q]);
  endproperty
  a_mode_shared: assert property (p_mode_shared) else $error("shared");

  property p_pd;
    @(posedge ref_clk) disable iff (reset)
    powerCtl_q[PdABit] && !bindA |=> chanAPowerDown;
  endproperty
  a_pd: assert property (p_pd) else $error("power down");

  property p_pd_b;
    @(posedge ref_clk) disable iff (reset)
    powerCtl_q[PdBBit] && bindB |=> chanBPowerDown;
  endproperty
  a_pd_b: assert property (p_pd_b) else $error("power down b");

  ////////////////////////////////////////////////////////////////////////////
  // Flag checks for the remaining pins
  property p_hit_one_b;
    @(posedge ref_clk) disable iff (reset)
    pinEn && hitB[1] |=> flagPins.flagB[1];
  endproperty
  a_hit_one_b: assert property (p_hit_one_b) else $error("t1 flag b");

  property p_hit_zero_a;
    @(posedge ref_clk) disable iff (reset)
    pinEn && hitA[0] |=> flagPins.flagA[0];
  endproperty
  a_hit_zero_a: assert property (p_hit_zero_a) else $error("t0 flag a");

  property p_embed_b;
    @(posedge ref_clk) disable iff (reset)
    !pdB |=> digBSample[SampleW+1:SampleW] == $past(hitB);
  endproperty
  a_embed_b: assert property (p_embed_b) else $error("embed b");

  property p_reload;
    @(posedge ref_clk) disable iff (reset)
    hitAll[0] |=> holdCnt_q[0] == $past(holdLen) - CntOne;
  endproperty
  a_reload: assert property (p_reload) else $error("hold reload");

  property p_release;
    @(posedge ref_clk) disable iff (reset)
    stretch_q[0] && !hitAll[0] && holdCnt_q[0] != CntZero |=> stretch_q[0];
  endproperty
  a_release: assert property (p_release) else $error("early release");

  ////////////////////////////////////////////////////////////////////////////
  // Selection, binding and bus checks
  property p_mode_reg_a;
    @(posedge ref_clk) disable iff (reset)
    mode == ONC_SRC_REG |=>
      chanAActive == $past(chanAPresets[presetSel_q[SelAHi:SelALo]]);
  endproperty
  a_mode_reg_a: assert property (p_mode_reg_a) else $error("reg a");

  property p_mode_split;
    @(posedge ref_clk) disable iff (reset)
    mode == ONC_SRC_SPLIT |=>
      chanAActive == $past(chanAPresets[pinsA_q]) &&
      chanBActive == $past(chanBPresets[pinsB_q]);
  endproperty
  a_mode_split: assert property (p_mode_split) else $error("split");

  property p_src_a;
    @(posedge ref_clk) disable iff (reset)
    !pdA && bindA |=> digASample[SampleW-1:0] == $past(convBSample);
  endproperty
  a_src_a: assert property (p_src_a) else $error("bind a");

  property p_src_b;
    @(posedge ref_clk) disable iff (reset)
    !pdB && !bindB |=> digBSample[SampleW-1:0] == $past(convASample);
  endproperty
  a_src_b: assert property (p_src_b) else $error("bind b");

  property p_div;
    @(posedge ref_clk) disable iff (reset)
    1'b1 |=> rationalDivisor == $past(div_q);
  endproperty
  a_div: assert property (p_div) else $error("divisor copy");

  // Read data only stands in the cycle after a read strobe
  property p_rd_idle;
    @(posedge ref_clk) disable iff (reset)
    !regRead |=> regRdData == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read idle");
endmodule
`default_nettype wire

// *** logic/onc_pkg.sv ***
// Package: register map, fields and types of the over-range and preset block
`default_nettype none
package onc_pkg;
  localparam int AddrW = 10;
  localparam logic [9:0] OffThreshZero = 10'h211;
  localparam logic [9:0] OffThreshOne = 10'h212;
  localparam logic [9:0] OffOvrCfg = 10'h213;
  localparam logic [9:0] OffSrcMode = 10'h214;
  localparam logic [9:0] OffPresetSel = 10'h215;
  localparam logic [9:0] OffBinding = 10'h216;
  localparam logic [9:0] OffDivLow = 10'h217;
  localparam logic [9:0] OffDivHigh = 10'h218;
  localparam logic [9:0] OffPowerCtl = 10'h220;
  localparam logic [9:0] OffStatus = 10'h221;
  localparam logic [7:0] RstThreshZero = 8'hF2;
  localparam logic [7:0] RstThreshOne = 8'hAB;
  localparam logic [7:0] RstOvrCfg = 8'h07;
  localparam logic [7:0] RstSrcMode = 8'h00;
  localparam logic [7:0] RstPresetSel = 8'h00;
  localparam logic [7:0] RstBinding = 8'h02;
  localparam logic [15:0] RstDiv = 16'h0000;
  localparam logic [7:0] RstPowerCtl = 8'h00;
  localparam int PinEnBit = 3;
  localparam int ExpHi = 2;
  localparam int SelBHi = 3;
  localparam int SelBLo = 2;
  localparam int SelAHi = 1;
  localparam int SelALo = 0;
  localparam int BindABit = 0;
  localparam int BindBBit = 1;
  localparam int PdABit = 0;
  localparam int PdBBit = 1;
  localparam int LinkEnBit = 2;
  localparam int CalEnBit = 3;
  localparam int BaseCyclesLog = 3;
  localparam int CntW = 11;
  localparam int SampleW = 12;
  localparam int ThreshW = 8;
  localparam int FreqW = 32;
  localparam int PhaseW = 16;
  localparam int Presets = 4;
  localparam logic [CntW-1:0] CntOne = 11'h001;
  localparam logic [CntW-1:0] CntZero = 11'h000;
  typedef enum logic [1:0] {
    ONC_SRC_REG = 2'h0,
    ONC_SRC_SPLIT = 2'h1,
    ONC_SRC_SHARED = 2'h2,
    ONC_SRC_RSVD = 2'h3
  } onc_src_type;
  typedef struct packed {
    logic [FreqW-1:0] freq;
    logic [PhaseW-1:0] phase;
  } onc_preset_type;
  typedef struct packed {
    logic [1:0] flagA;
    logic [1:0] flagB;
  } onc_flags_type;
endpackage
`default_nettype wire
